// *** hw/rtp_defs.svh ***
// Offsets, field positions, reset values and timing counts of the tick unit.
`ifndef RTP_DEFS_SVH
`define RTP_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RTP_OFS_TIMEKEEPER_CONTROL_A 5'h00
`define RTP_OFS_STATUS 5'h01
`define RTP_OFS_INTEN 5'h02
`define RTP_OFS_INTFLG 5'h03
`define RTP_OFS_TEMP 5'h04
`define RTP_OFS_DBG 5'h05
`define RTP_OFS_CLOCK_SOURCE_SELECT 5'h07
`define RTP_OFS_CNT_L 5'h08
`define RTP_OFS_CNT_H 5'h09
`define RTP_OFS_TOP_L 5'h0A
`define RTP_OFS_TOP_H 5'h0B
`define RTP_OFS_MATCH_L 5'h0C
`define RTP_OFS_MATCH_H 5'h0D
`define RTP_OFS_PCTRL 5'h10
`define RTP_OFS_PSTATUS 5'h11
`define RTP_OFS_PINTEN 5'h12
`define RTP_OFS_PINTFLG 5'h13
`define RTP_OFS_PDBG 5'h15

// ****************************************************************
// Field positions
// ****************************************************************
`define RTP_BIT_RUN_STBY 7
`define RTP_BIT_ENABLE 0
`define RTP_PRESC_MSB 6
`define RTP_PRESC_LSB 3
`define RTP_BIT_CMP 1
`define RTP_BIT_OVF 0
`define RTP_BIT_PIRQ 0
`define RTP_BIT_RUN_HALT 0

// ****************************************************************
// Sync slots, reset values and timing
// ****************************************************************
`define RTP_SLOT_TIMEKEEPER_CONTROL_A 0
`define RTP_SLOT_CNT 1
`define RTP_SLOT_TOP 2
`define RTP_SLOT_MATCH 3
`define RTP_SLOT_PCTRL 4
`define RTP_NUM_SLOTS 5
`define RTP_SYNC_TICKS 2'h2
`define RTP_RST_BYTE 8'h00
`define RTP_RST_TOP 16'hFFFF
`define RTP_RST_WORD 16'h0000
`define RTP_PERIOD_OFF 4'h0
`define RTP_PERIOD_BAD 4'hF

`endif

// *** hw/rtp_pkg.sv ***
// Types shared by the tick unit.
`default_nettype none
package rtp_pkg;
  typedef logic [7:0] rtp_byte_t;
  typedef logic [15:0] rtp_word_t;
  typedef enum logic [1:0] {
    RTP_SRC_ULP32K,
    RTP_SRC_ULP1K,
    RTP_SRC_XTAL,
    RTP_SRC_EXT
  } rtp_clk_src_t;
endpackage
`default_nettype wire

// *** hw/rtp_tick_unit.sv ***
// Real-time counter and periodic tick timer behind a byte register port.
// ****************************************************************
// Functional notes
// R1: Periodic timer runs only while enabled.
// R2: Software configures clock, period, irq, enable.
// R3: Overflow event when counter wraps at top.
// R4: Compare event when counter equals match value.
// R5: Eight periodic events, 8192 down to 64.
// R6: Counter and periodic interrupt vectors separate.
// R7: Periodic irq after selected period elapses.
// R8: Flags set regardless of interrupt enable.
// R9: Request held while enable and flag set.
// R10: Each interrupt source individually enabled.
// R11: Counter runs idle; standby needs bit.
// R12: Run-in-standby is control bit seven.
// R13: Periodic timer runs in every sleep.
// R14: Slow clock counts; writes synchronised.
// R15: Status busy flags for four registers.
// R16: Periodic status busy flag bit zero.
// R17: Software polls busy before writing.
// R18: Writing one clears a flag.
// R19: Prescaler divides by two power field.
// R20: Two-bit field selects slow clock source.
// R21: Writes take effect two slow cycles later.
// R22: Period field four to 32768, zero off.
// R23: Sixteen-bit access through shared byte latch.
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "rtp_defs.svh"

module rtp_tick_unit
  import rtp_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  // Slow clock candidates and system state
  input wire logic [3:0] i_src_clk,
  input wire logic i_sleep_standby,
  input wire logic i_dbg_halt,
  // Events and interrupt vectors
  output logic o_ovf_evt,
  output logic o_cmp_evt,
  output logic [7:0] o_pit_evt,
  output logic o_cnt_irq,
  output logic o_pit_irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [14:0] mask_of(input logic [3:0] p);
    mask_of = (15'h0001 << p) - 15'h0001;
  endfunction

  function automatic logic wr_at(input logic [4:0] a);
    wr_at = i_wr_en && (i_addr == a);
  endfunction

  // ****************************************************************
  // Software visible state
  // ****************************************************************
  rtp_byte_t timekeeper_control_a_reg, inten_reg, flags_reg, temp_reg, dbg_reg, clock_source_select_reg;
  rtp_byte_t pctrl_reg, pinten_reg, pflags_reg, pdbg_reg;
  rtp_word_t cnt_reg, cnt_wr_reg, top_reg, match_reg;
  rtp_byte_t timekeeper_control_a_act_reg, pctrl_act_reg;
  rtp_word_t top_act_reg, match_act_reg;
  logic [1:0] sync_cnt_reg [`RTP_NUM_SLOTS];
  logic [`RTP_NUM_SLOTS-1:0] busy;
  logic [`RTP_NUM_SLOTS-1:0] apply;
  logic [`RTP_NUM_SLOTS-1:0] start;

  // ****************************************************************
  // Slow clock selection and synchroniser
  // ****************************************************************
  logic [2:0] sync_reg;
  logic lvl_reg;
  logic slow_tick;
  logic src_sel;

  // R20: source mux
  always_comb begin
    case (rtp_clk_src_t'(clock_source_select_reg[1:0]))
      RTP_SRC_ULP32K: src_sel = i_src_clk[0];
      RTP_SRC_ULP1K: src_sel = i_src_clk[1];
      RTP_SRC_XTAL: src_sel = i_src_clk[2];
      RTP_SRC_EXT: src_sel = i_src_clk[3];
      default: src_sel = 1'b0;
    endcase
  end

  // R14: slow clock sampled, edge on agreement
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync_reg <= 3'h0;
      lvl_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], src_sel};
      if (sync_reg[1] == sync_reg[2]) begin
        lvl_reg <= sync_reg[2];
      end
    end
  end

  assign slow_tick = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !lvl_reg;

  // ****************************************************************
  // Write synchronisation
  // ****************************************************************
  // A process, not assigns, so the strobe and address read inside the helper wake it.
  always_comb begin
    start[`RTP_SLOT_TIMEKEEPER_CONTROL_A] = wr_at(`RTP_OFS_TIMEKEEPER_CONTROL_A);
    start[`RTP_SLOT_CNT] = wr_at(`RTP_OFS_CNT_H);
    start[`RTP_SLOT_TOP] = wr_at(`RTP_OFS_TOP_H);
    start[`RTP_SLOT_MATCH] = wr_at(`RTP_OFS_MATCH_H);
    start[`RTP_SLOT_PCTRL] = wr_at(`RTP_OFS_PCTRL);
  end

  // R21: two slow ticks before a write applies
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < `RTP_NUM_SLOTS; i++) begin
        sync_cnt_reg[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < `RTP_NUM_SLOTS; i++) begin
        if (start[i]) begin
          sync_cnt_reg[i] <= `RTP_SYNC_TICKS;
        end else if (slow_tick && sync_cnt_reg[i] != 2'h0) begin
          sync_cnt_reg[i] <= sync_cnt_reg[i] - 2'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `RTP_NUM_SLOTS; i++) begin
      busy[i] = (sync_cnt_reg[i] != 2'h0);
      apply[i] = slow_tick && (sync_cnt_reg[i] == 2'h1) && !start[i];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      timekeeper_control_a_act_reg <= `RTP_RST_BYTE;
      top_act_reg <= `RTP_RST_TOP;
      match_act_reg <= `RTP_RST_WORD;
      pctrl_act_reg <= `RTP_RST_BYTE;
    end else begin
      if (apply[`RTP_SLOT_TIMEKEEPER_CONTROL_A]) begin
        timekeeper_control_a_act_reg <= timekeeper_control_a_reg;
      end
      if (apply[`RTP_SLOT_TOP]) begin
        top_act_reg <= top_reg;
      end
      if (apply[`RTP_SLOT_MATCH]) begin
        match_act_reg <= match_reg;
      end
      if (apply[`RTP_SLOT_PCTRL]) begin
        pctrl_act_reg <= pctrl_reg;
      end
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // R23: low byte parks in the latch, high byte commits the word
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      timekeeper_control_a_reg <= `RTP_RST_BYTE;
      inten_reg <= `RTP_RST_BYTE;
      temp_reg <= `RTP_RST_BYTE;
      dbg_reg <= `RTP_RST_BYTE;
      clock_source_select_reg <= `RTP_RST_BYTE;
      pctrl_reg <= `RTP_RST_BYTE;
      pinten_reg <= `RTP_RST_BYTE;
      pdbg_reg <= `RTP_RST_BYTE;
      cnt_wr_reg <= `RTP_RST_WORD;
      top_reg <= `RTP_RST_TOP;
      match_reg <= `RTP_RST_WORD;
    end else begin
      if (wr_at(`RTP_OFS_TIMEKEEPER_CONTROL_A)) begin
        timekeeper_control_a_reg <= {i_wr_data[7:3], 2'h0, i_wr_data[0]};
      end
      // R10: per-source enables
      if (wr_at(`RTP_OFS_INTEN)) begin
        inten_reg <= {6'h00, i_wr_data[1:0]};
      end
      if (wr_at(`RTP_OFS_DBG)) begin
        dbg_reg <= {7'h00, i_wr_data[0]};
      end
      if (wr_at(`RTP_OFS_CLOCK_SOURCE_SELECT)) begin
        clock_source_select_reg <= {6'h00, i_wr_data[1:0]};
      end
      if (wr_at(`RTP_OFS_PCTRL)) begin
        pctrl_reg <= {1'b0, i_wr_data[6:3], 2'h0, i_wr_data[0]};
      end
      if (wr_at(`RTP_OFS_PINTEN)) begin
        pinten_reg <= {7'h00, i_wr_data[0]};
      end
      if (wr_at(`RTP_OFS_PDBG)) begin
        pdbg_reg <= {7'h00, i_wr_data[0]};
      end
      if (wr_at(`RTP_OFS_TEMP) || wr_at(`RTP_OFS_CNT_L) || wr_at(`RTP_OFS_TOP_L) ||
          wr_at(`RTP_OFS_MATCH_L)) begin
        temp_reg <= i_wr_data;
      end else if (i_rd_en && i_addr == `RTP_OFS_CNT_L) begin
        temp_reg <= cnt_reg[15:8];
      end else if (i_rd_en && i_addr == `RTP_OFS_TOP_L) begin
        temp_reg <= top_reg[15:8];
      end else if (i_rd_en && i_addr == `RTP_OFS_MATCH_L) begin
        temp_reg <= match_reg[15:8];
      end
      if (start[`RTP_SLOT_CNT]) begin
        cnt_wr_reg <= {i_wr_data, temp_reg};
      end
      if (start[`RTP_SLOT_TOP]) begin
        top_reg <= {i_wr_data, temp_reg};
      end
      if (start[`RTP_SLOT_MATCH]) begin
        match_reg <= {i_wr_data, temp_reg};
      end
    end
  end

  // ****************************************************************
  // Real-time counter
  // ****************************************************************
  logic [14:0] presc_reg;
  logic cnt_run;
  logic cnt_tick;
  logic ovf_hit;
  logic cmp_hit;

  // R11: idle keeps running, standby needs the bit
  // R12: bit seven of the active control byte
  assign cnt_run = timekeeper_control_a_act_reg[`RTP_BIT_ENABLE] &&
                   !(i_sleep_standby && !timekeeper_control_a_act_reg[`RTP_BIT_RUN_STBY]) &&
                   !(i_dbg_halt && !dbg_reg[`RTP_BIT_RUN_HALT]);

  // R19: tick when the masked prescaler bits are all ones
  assign cnt_tick = cnt_run && slow_tick &&
                    ((presc_reg & mask_of(timekeeper_control_a_act_reg[`RTP_PRESC_MSB:`RTP_PRESC_LSB])) ==
                     mask_of(timekeeper_control_a_act_reg[`RTP_PRESC_MSB:`RTP_PRESC_LSB]));
  assign ovf_hit = cnt_tick && (cnt_reg == top_act_reg);
  assign cmp_hit = cnt_tick && (cnt_reg == match_act_reg);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      presc_reg <= 15'h0000;
    end else if (!cnt_run) begin
      presc_reg <= 15'h0000;
    end else if (slow_tick) begin
      presc_reg <= presc_reg + 15'h0001;
    end
  end

  // R3: wrap to zero at top
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_reg <= `RTP_RST_WORD;
    end else if (apply[`RTP_SLOT_CNT]) begin
      cnt_reg <= cnt_wr_reg;
    end else if (ovf_hit) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // R4: compare and overflow event pulses
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ovf_evt <= 1'b0;
      o_cmp_evt <= 1'b0;
    end else begin
      o_ovf_evt <= ovf_hit;
      o_cmp_evt <= cmp_hit;
    end
  end

  // ****************************************************************
  // Periodic tick timer
  // ****************************************************************
  logic [14:0] pit_reg;
  logic [14:0] pit_next;
  logic pit_run;
  logic pit_step;
  logic [3:0] pit_period;
  logic pit_hit;
  logic [7:0] pit_evt;

  // R1: enable taken from the synchronised control copy
  // R13: no sleep term, only debug halt
  assign pit_run = pctrl_act_reg[`RTP_BIT_ENABLE] &&
                   !(i_dbg_halt && !pdbg_reg[`RTP_BIT_RUN_HALT]);
  assign pit_step = pit_run && slow_tick;
  assign pit_next = pit_reg + 15'h0001;
  assign pit_period = pctrl_act_reg[`RTP_PRESC_MSB:`RTP_PRESC_LSB];

  // R22: field v gives an interval of 2 to the v plus one
  assign pit_hit = pit_step && pit_period != `RTP_PERIOD_OFF &&
                   pit_period != `RTP_PERIOD_BAD &&
                   ((pit_next & mask_of(pit_period + 4'h1)) == 15'h0000);

  // R5: event n every 8192 shifted right by n
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      pit_evt[n] = pit_step && ((pit_next & mask_of(4'(13 - n))) == 15'h0000);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pit_reg <= 15'h0000;
    end else if (!pctrl_act_reg[`RTP_BIT_ENABLE]) begin
      pit_reg <= 15'h0000;
    end else if (pit_step) begin
      pit_reg <= pit_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pit_evt <= 8'h00;
    end else begin
      o_pit_evt <= pit_evt;
    end
  end

  // ****************************************************************
  // Flags and interrupt vectors
  // ****************************************************************
  // R8: set wins over a same-cycle clear
  // R18: writing ones clears flags
  // R7: periodic flag on elapsed period
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flags_reg <= `RTP_RST_BYTE;
      pflags_reg <= `RTP_RST_BYTE;
    end else begin
      flags_reg[`RTP_BIT_OVF] <= (flags_reg[`RTP_BIT_OVF] &&
                                  !(wr_at(`RTP_OFS_INTFLG) && i_wr_data[`RTP_BIT_OVF])) ||
                                 ovf_hit;
      flags_reg[`RTP_BIT_CMP] <= (flags_reg[`RTP_BIT_CMP] &&
                                  !(wr_at(`RTP_OFS_INTFLG) && i_wr_data[`RTP_BIT_CMP])) ||
                                 cmp_hit;
      pflags_reg[`RTP_BIT_PIRQ] <= (pflags_reg[`RTP_BIT_PIRQ] &&
                                    !(wr_at(`RTP_OFS_PINTFLG) && i_wr_data[`RTP_BIT_PIRQ])) ||
                                   pit_hit;
    end
  end

  // R6: two separate vectors
  // R9: request follows enable and flag
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cnt_irq <= 1'b0;
      o_pit_irq <= 1'b0;
    end else begin
      o_cnt_irq <= |(flags_reg[1:0] & inten_reg[1:0]);
      o_pit_irq <= pflags_reg[`RTP_BIT_PIRQ] && pinten_reg[`RTP_BIT_PIRQ];
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // R15: four busy flags
  // R16: periodic busy flag
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else if (!i_rd_en) begin
      o_rd_data <= 8'h00;
    end else begin
      case (i_addr)
        `RTP_OFS_TIMEKEEPER_CONTROL_A: o_rd_data <= timekeeper_control_a_reg;
        `RTP_OFS_STATUS: o_rd_data <= {4'h0, busy[`RTP_SLOT_MATCH], busy[`RTP_SLOT_TOP],
                                       busy[`RTP_SLOT_CNT], busy[`RTP_SLOT_TIMEKEEPER_CONTROL_A]};
        `RTP_OFS_INTEN: o_rd_data <= inten_reg;
        `RTP_OFS_INTFLG: o_rd_data <= {6'h00, flags_reg[1:0]};
        `RTP_OFS_TEMP: o_rd_data <= temp_reg;
        `RTP_OFS_DBG: o_rd_data <= dbg_reg;
        `RTP_OFS_CLOCK_SOURCE_SELECT: o_rd_data <= clock_source_select_reg;
        `RTP_OFS_CNT_L: o_rd_data <= cnt_reg[7:0];
        `RTP_OFS_CNT_H: o_rd_data <= temp_reg;
        `RTP_OFS_TOP_L: o_rd_data <= top_reg[7:0];
        `RTP_OFS_TOP_H: o_rd_data <= temp_reg;
        `RTP_OFS_MATCH_L: o_rd_data <= match_reg[7:0];
        `RTP_OFS_MATCH_H: o_rd_data <= temp_reg;
        `RTP_OFS_PCTRL: o_rd_data <= pctrl_reg;
        `RTP_OFS_PSTATUS: o_rd_data <= {7'h00, busy[`RTP_SLOT_PCTRL]};
        `RTP_OFS_PINTEN: o_rd_data <= pinten_reg;
        `RTP_OFS_PINTFLG: o_rd_data <= {7'h00, pflags_reg[`RTP_BIT_PIRQ]};
        `RTP_OFS_PDBG: o_rd_data <= pdbg_reg;
        default: o_rd_data <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  pit_stopped_a: assert property (!pctrl_act_reg[0] |=> o_pit_evt == 8'h00) // R1
    else $error("periodic event while timer disabled");
  ovf_wrap_a: assert property ((ovf_hit && !apply[1]) |=> (cnt_reg == 16'h0000) && o_ovf_evt) // R3
    else $error("counter did not wrap on overflow");
  cmp_event_a: assert property (cmp_hit |=> o_cmp_evt) // R4
    else $error("compare event missing");
  pit_evt7_a: assert property (o_pit_evt[7] |-> pit_reg[5:0] == 6'h00) // R5
    else $error("event seven off its 64 tick grid");
  pit_nest_a: assert property (o_pit_evt[6] |-> o_pit_evt[7]) // R5
    else $error("event six not on the event seven grid");
  flag_set_a: assert property (o_ovf_evt |-> flags_reg[0]) // R8
    else $error("overflow flag not set with event");
  irq_hold_a: assert property ((pflags_reg[0] && pinten_reg[0]) [*2] |-> ##1 o_pit_irq) // R9
    else $error("periodic request not held");
  busy_set_a: assert property (start[3] |=> busy[3] ##1 busy[3]) // R15
    else $error("compare busy flag not raised");
  sync_apply_a: assert property ($fell(busy[0]) |-> timekeeper_control_a_act_reg == timekeeper_control_a_reg) // R21
    else $error("control copy not applied at end of sync");
  standby_a: assert property ((i_sleep_standby && !timekeeper_control_a_act_reg[7]) |-> !cnt_tick) // R11
    else $error("counter ticked in standby without the bit");
  w1c_clear_a: assert property ((wr_at(5'h03) && i_wr_data[1] && !cmp_hit) |=> !flags_reg[1]) // R18
    else $error("compare flag not cleared by write of one");

  wrap_seen_c: cover property (ovf_hit ##[1:1000] cmp_hit);
  pit_irq_c: cover property (pit_hit ##1 pflags_reg[0] ##1 o_pit_irq);
  cnt_load_c: cover property (start[1] ##[1:300] apply[1]);

endmodule
`default_nettype wire

// *** verif/rtp_far_side.sv ***
// Event router stand-in that counts the overflow, compare and event seven lines and times the overflow and event seven lines.
`timescale 1ns/10ps
`default_nettype none

module rtp_far_side (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Observed event lines
  input wire logic i_ovf_evt,
  input wire logic i_cmp_evt,
  input wire logic [7:0] i_pit_evt,
  // Measurements
  output logic [31:0] o_ovf_cnt,
  output logic [31:0] o_cmp_cnt,
  output logic [31:0] o_pit_cnt,
  output logic [31:0] o_ovf_gap,
  output logic [31:0] o_pit_gap
);
  logic [31:0] cyc_reg;
  logic [31:0] ovf_last_reg;
  logic [31:0] pit_last_reg;

  // ****************************************************************
  // Event timing
  // ****************************************************************
  // The router keeps the two vectors' sources apart, so each is counted alone.
  // separate event sources.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cyc_reg <= 32'h0;
      ovf_last_reg <= 32'h0;
      pit_last_reg <= 32'h0;
      o_ovf_cnt <= 32'h0;
      o_cmp_cnt <= 32'h0;
      o_pit_cnt <= 32'h0;
      o_ovf_gap <= 32'h0;
      o_pit_gap <= 32'h0;
    end else begin
      cyc_reg <= cyc_reg + 32'h1;
      if (i_ovf_evt) begin
        o_ovf_cnt <= o_ovf_cnt + 32'h1;
        o_ovf_gap <= cyc_reg - ovf_last_reg;
        ovf_last_reg <= cyc_reg;
      end
      if (i_cmp_evt) begin
        o_cmp_cnt <= o_cmp_cnt + 32'h1;
      end
      if (i_pit_evt[7]) begin
        o_pit_cnt <= o_pit_cnt + 32'h1;
        o_pit_gap <= cyc_reg - pit_last_reg;
        pit_last_reg <= cyc_reg;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/test_rtp_tick_unit.sv ***
// Self-checking bench for the counter and periodic tick unit.
`timescale 1ns/10ps
`default_nettype none
`include "rtp_defs.svh"

module test_rtp_tick_unit import rtp_pkg::*;;
  // Slow clock period in ns; not a multiple of the bus period on purpose.
  localparam int SLOW_NS = 401;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_sleep_standby = 1'b0;
  logic s0 = 1'b0;
  logic s1 = 1'b0;
  logic s2 = 1'b0;
  logic s3 = 1'b0;
  wire logic [3:0] i_src_clk;
  logic [7:0] o_rd_data;
  logic o_ovf_evt;
  logic o_cmp_evt;
  logic [7:0] o_pit_evt;
  logic o_cnt_irq;
  logic o_pit_irq;
  logic [31:0] ovf_cnt;
  logic [31:0] cmp_cnt;
  logic [31:0] pit_cnt;
  logic [31:0] ovf_gap;
  logic [31:0] pit_gap;
  int bad_count = 0;
  int n_compared = 0;
  int seed = 32'h09C4;
  int exp_q[$];
  rtp_byte_t rd_val;
  logic [4:0] rw_ofs [10] = '{`RTP_OFS_INTEN, `RTP_OFS_TEMP, `RTP_OFS_DBG, `RTP_OFS_CLOCK_SOURCE_SELECT,
    `RTP_OFS_PINTEN, `RTP_OFS_PDBG, `RTP_OFS_STATUS, `RTP_OFS_INTFLG, `RTP_OFS_PINTFLG, 5'h06};
  rtp_byte_t rw_msk [10] = '{8'h03, 8'hFF, 8'h01, 8'h03, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

  assign i_src_clk = {s3, s2, s1, s0};
  always #12.5 i_ref_clk = ~i_ref_clk;
  always #(SLOW_NS / 2.0) s0 = ~s0;
  always #1001.5 s1 = ~s1;
  always #305.5 s2 = ~s2;
  always #366.5 s3 = ~s3;

  rtp_tick_unit rtp_tick_unit_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_src_clk(i_src_clk), .i_sleep_standby(i_sleep_standby), .i_dbg_halt(1'b0),
    .o_ovf_evt(o_ovf_evt), .o_cmp_evt(o_cmp_evt), .o_pit_evt(o_pit_evt),
    .o_cnt_irq(o_cnt_irq), .o_pit_irq(o_pit_irq));
  rtp_far_side rtp_far_side_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ovf_evt(o_ovf_evt),
    .i_cmp_evt(o_cmp_evt), .i_pit_evt(o_pit_evt), .o_ovf_cnt(ovf_cnt), .o_cmp_cnt(cmp_cnt),
    .o_pit_cnt(pit_cnt), .o_ovf_gap(ovf_gap), .o_pit_gap(pit_gap));

  // ****************************************************************
  // Bus cycles and comparisons
  // ****************************************************************
  task conclude();
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Slow ticks wander against the bus clock, so spacings get a small margin.
  task chk_near(input string what, input int exp, input logic [31:0] got);
    n_compared++;
    if ($isunknown(got) || got + 3 < exp || got > exp + 3) begin
      bad_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task tick();
    @(posedge i_ref_clk);
    #1;
  endtask
  task wr(input logic [4:0] a, input rtp_byte_t d);
    @(posedge i_ref_clk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
  endtask
  task rd(input logic [4:0] a);
    @(posedge i_ref_clk);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1;
    rd_val = o_rd_data;
  endtask
  task sync_wait(input logic [4:0] a, input int b);
    int k;
    rd(a);
    chk("busy after write", 1, rd_val[b]);
    for (k = 0; k < 40 && rd_val[b] !== 1'b0; k++) rd(a);
    chk("busy span", 1, k >= 5 && k <= 24);
  endtask
  function automatic logic [31:0] ev(input int w);
    return w == 0 ? ovf_cnt : pit_cnt;
  endfunction
  task wait_ev(input int w, input int n);
    logic [31:0] s;
    int k;
    s = ev(w);
    for (k = 0; k < 20000 && ev(w) < s + n; k++) tick();
    chk("event arrival", 1, ev(w) >= s + n);
  endtask

  initial begin
    repeat (60000) @(posedge i_ref_clk);
    bad_count++;
    conclude();
  end

  initial begin
    int k;
    int p;
    rtp_byte_t v;
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    foreach (rw_ofs[i]) begin
      rd(rw_ofs[i]);
      chk("reset value", 8'h00, rd_val);
    end
    rd(`RTP_OFS_TOP_L);
    chk("top low at reset", 8'hFF, rd_val);
    rd(`RTP_OFS_TOP_H);
    chk("top high at reset", 8'hFF, rd_val);
    foreach (rw_ofs[i]) begin
      v = rtp_byte_t'($random(seed));
      wr(rw_ofs[i], v);
      exp_q.push_back(v & rw_msk[i]);
    end
    foreach (rw_ofs[i]) begin
      rd(rw_ofs[i]);
      chk("register readback", exp_q[i], rd_val);
    end
    wr(`RTP_OFS_CLOCK_SOURCE_SELECT, 8'h00);
    wr(`RTP_OFS_TOP_L, 8'h03);
    wr(`RTP_OFS_TOP_H, 8'h00);
    sync_wait(`RTP_OFS_STATUS, 2);
    wr(`RTP_OFS_MATCH_L, 8'h02);
    wr(`RTP_OFS_MATCH_H, 8'h00);
    sync_wait(`RTP_OFS_STATUS, 3);
    wr(`RTP_OFS_INTEN, 8'h01);
    for (p = 0; p < 3; p++) begin
      wr(`RTP_OFS_TIMEKEEPER_CONTROL_A, rtp_byte_t'((p << 3) | 1));
      sync_wait(`RTP_OFS_STATUS, 0);
      wait_ev(0, 3);
      chk_near("overflow spacing", 4 * (1 << p) * SLOW_NS / 25, ovf_gap);
    end
    chk_near("compare count", ovf_cnt, cmp_cnt);
    rd(`RTP_OFS_INTFLG);
    chk("counter flags", 8'h03, rd_val);
    chk("counter request", 1'b1, o_cnt_irq);
    wr(`RTP_OFS_INTEN, 8'h00);
    repeat (3) tick();
    chk("masked request", 1'b0, o_cnt_irq);
    i_sleep_standby <= 1'b1;
    repeat (10) tick();
    k = ovf_cnt;
    wr(`RTP_OFS_PCTRL, 8'h08);
    sync_wait(`RTP_OFS_PSTATUS, 0);
    wr(`RTP_OFS_PINTEN, 8'h01);
    wr(`RTP_OFS_PCTRL, 8'h09);
    sync_wait(`RTP_OFS_PSTATUS, 0);
    wait_ev(2, 3);
    chk_near("tick event spacing", 64 * SLOW_NS / 25, pit_gap);
    rd(`RTP_OFS_PINTFLG);
    chk("periodic flag", 8'h01, rd_val);
    chk("periodic request", 1'b1, o_pit_irq);
    wr(`RTP_OFS_PINTFLG, 8'h01);
    for (p = 0; p < 400 && o_pit_irq !== 1'b0; p++) tick();
    for (p = 0; p < 400 && o_pit_irq !== 1'b1; p++) tick();
    wr(`RTP_OFS_PINTFLG, 8'h01);
    repeat (2) tick();
    for (p = 4; p < 400 && o_pit_irq !== 1'b1; p++) tick();
    chk_near("periodic interval", 4 * SLOW_NS / 25, p);
    chk("standby halt", k, ovf_cnt);
    wr(`RTP_OFS_TIMEKEEPER_CONTROL_A, 8'h91);
    sync_wait(`RTP_OFS_STATUS, 0);
    wait_ev(0, 2);
    wr(`RTP_OFS_CLOCK_SOURCE_SELECT, 8'h03);
    wait_ev(0, 3);
    chk_near("external source spacing", 16 * 733 / 25, ovf_gap);
    wr(`RTP_OFS_CLOCK_SOURCE_SELECT, 8'h00);
    wr(`RTP_OFS_PCTRL, 8'h08);
    sync_wait(`RTP_OFS_PSTATUS, 0);
    wr(`RTP_OFS_TIMEKEEPER_CONTROL_A, 8'h00);
    sync_wait(`RTP_OFS_STATUS, 0);
    repeat (10) tick();
    k = pit_cnt;
    wr(`RTP_OFS_INTFLG, 8'h00);
    rd(`RTP_OFS_INTFLG);
    chk("zero write keeps flags", 8'h03, rd_val);
    wr(`RTP_OFS_INTFLG, 8'h01);
    rd(`RTP_OFS_INTFLG);
    chk("one write clears flag", 8'h02, rd_val);
    wr(`RTP_OFS_INTEN, 8'h02);
    repeat (3) tick();
    chk("compare request", 1'b1, o_cnt_irq);
    wr(`RTP_OFS_INTFLG, 8'h02);
    repeat (3) tick();
    chk("request released", 1'b0, o_cnt_irq);
    wr(`RTP_OFS_CNT_L, 8'h34);
    wr(`RTP_OFS_CNT_H, 8'h12);
    sync_wait(`RTP_OFS_STATUS, 1);
    rd(`RTP_OFS_CNT_L);
    chk("count low byte", 8'h34, rd_val);
    rd(`RTP_OFS_CNT_H);
    chk("count high byte", 8'h12, rd_val);
    rd(`RTP_OFS_TOP_L);
    rd(`RTP_OFS_TOP_H);
    chk("top high byte", 8'h00, rd_val);
    repeat (2000) tick();
    chk("tick events stopped", k, pit_cnt);
    conclude();
  end
endmodule
`default_nettype wire
